// >>> inc/serial_port_pkg.sv
package serial_port_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned MS_DIV_W = 18;
  localparam int unsigned ADDR_W = 8;
  // Cycles per bit at each selectable rate
  localparam logic [15:0] BIT_9600 = 16'(CLK_HZ / 9600);
  localparam logic [15:0] BIT_19200 = 16'(CLK_HZ / 19200);
  localparam logic [15:0] BIT_38400 = 16'(CLK_HZ / 38400);
  localparam logic [15:0] BIT_57600 = 16'(CLK_HZ / 57600);
  localparam int unsigned FRAME_W = 12;
  // Response delay in ms: limit 99, default 20
  localparam logic [6:0] DELAY_MAX_MS = 7'h63;
  localparam logic [6:0] DELAY_DEF_MS = 7'h14;
  // Receive buffer depth: 217 bytes
  localparam logic [7:0] RX_DEPTH = 8'hD9;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] BCC_INIT = 16'h0000;
  localparam logic [15:0] SLOPE_UNITY = 16'h0100;
  localparam int unsigned SCALE_SHIFT = 8;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] A_TXDATA = 8'h08;
  localparam logic [ADDR_W-1:0] A_RXDATA = 8'h0C;
  localparam logic [ADDR_W-1:0] A_DELAY = 8'h10;
  localparam logic [ADDR_W-1:0] A_CHECK = 8'h14;
  localparam logic [ADDR_W-1:0] A_SCALE = 8'h18;
  localparam logic [ADDR_W-1:0] A_SETPT = 8'h1C;
  localparam logic [ADDR_W-1:0] A_CMD = 8'h20;

  typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2} parity_t;
  typedef enum logic [1:0] {
    ROLE_RESPONDER = 2'h0, ROLE_MASTER = 2'h1, ROLE_SLAVE = 2'h2, ROLE_PLC = 2'h3
  } role_t;
  typedef struct packed {
    logic [1:0] baud;
    logic data8;
    logic stop2;
    parity_t parity;
  } line_cfg_t;
  typedef struct packed {
    logic modbus;
    role_t role;
    logic [4:0] station;
    line_cfg_t line;
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = '{1'b0, ROLE_RESPONDER, 5'h01, '{2'h0, 1'b1, 1'b0, PAR_NONE}};
  typedef struct packed {
    logic [7:0] data;
    logic perr;
    logic ferr;
  } rx_char_t;
  typedef struct packed {
    logic [7:0] count;
    logic delay_wait;
    logic addr_match;
    logic overflow;
    logic ferr;
    logic perr;
    logic rx_avail;
    logic tx_ready;
    logic rx_busy;
    logic tx_busy;
  } status_t;
  typedef struct packed {
    logic clr_err;
    logic clr_tx_chk;
    logic new_msg;
  } cmd_t;
endpackage : serial_port_pkg

// >>> verilog/serial_engine.sv
`timescale 1ns/1ps
`default_nettype none
module serial_engine (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Line format
  input wire serial_port_pkg::line_cfg_t cfg,
  // Transmit request
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  // Synchronised receive line
  input wire logic rxd,
  // Line drive
  output logic txd,
  output logic de,
  // Status and received character
  output logic tx_busy,
  output logic rx_busy,
  output logic rx_valid,
  output var serial_port_pkg::rx_char_t rx_char
);
  typedef enum logic {TX_IDLE = 1'b0, TX_RUN = 1'b1} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h3} rx_state_t;
  typedef struct packed {
    tx_state_t tx_st;
    logic [11:0] tx_sh;
    logic [3:0] tx_left;
    logic [15:0] tx_cnt;
    logic de;
    rx_state_t rx_st;
    logic [11:0] rx_sh;
    logic [3:0] rx_left;
    logic [15:0] rx_cnt;
    logic rx_valid;
    serial_port_pkg::rx_char_t rx_char;
  } eng_t;
  eng_t st;
  eng_t next_st;

  always_comb begin
    logic [15:0] bitc;
    logic [3:0] ndata;
    logic [3:0] nbits;
    logic [3:0] pbit;
    logic par_on;
    logic [7:0] d;
    logic [11:0] frame;
    logic [11:0] al;
    bitc = serial_port_pkg::BIT_9600;
    next_st = st;
    next_st.rx_valid = 1'b0;
    unique case (cfg.baud)
      2'h0: bitc = serial_port_pkg::BIT_9600;
      2'h1: bitc = serial_port_pkg::BIT_19200;
      2'h2: bitc = serial_port_pkg::BIT_38400;
      2'h3: bitc = serial_port_pkg::BIT_57600;
    endcase
    ndata = cfg.data8 ? 4'h8 : 4'h7;
    par_on = cfg.parity != serial_port_pkg::PAR_NONE;
    pbit = ndata + {3'h0, par_on};
    nbits = pbit + (cfg.stop2 ? 4'h3 : 4'h2);
    d = cfg.data8 ? tx_data : {1'b0, tx_data[6:0]};
    frame = {3'h7, d, 1'b0};
    frame[8] = cfg.data8 ? d[7] : 1'b1;
    if (par_on) begin
      frame[ndata + 4'h1] = (cfg.parity == serial_port_pkg::PAR_ODD) ? ~^d : ^d;
    end
    unique case (st.tx_st)
      TX_IDLE: if (tx_start) begin
        next_st.tx_st = TX_RUN;
        next_st.tx_sh = frame;
        next_st.tx_left = nbits;
        next_st.tx_cnt = bitc - 16'h1;
        next_st.de = 1'b1;
      end
      TX_RUN: if (st.tx_cnt == 16'h0) begin
        if (st.tx_left == 4'h1) begin
          next_st.tx_st = TX_IDLE;
          next_st.de = 1'b0;
          next_st.tx_sh = '1;
        end else begin
          next_st.tx_sh = {1'b1, st.tx_sh[11:1]};
          next_st.tx_left = st.tx_left - 4'h1;
          next_st.tx_cnt = bitc - 16'h1;
        end
      end else begin
        next_st.tx_cnt = st.tx_cnt - 16'h1;
      end
    endcase
    al = {rxd, st.rx_sh[11:1]} >> (4'hD - nbits);
    unique case (st.rx_st)
      // Own echo is never received while this end drives the line
      RX_IDLE: if (!rxd && st.tx_st == TX_IDLE && !st.de) begin
        next_st.rx_st = RX_START;
        next_st.rx_cnt = bitc >> 1;
      end
      RX_START: if (st.rx_cnt == 16'h0) begin
        // A start bit gone by mid-bit was noise
        next_st.rx_st = rxd ? RX_IDLE : RX_DATA;
        next_st.rx_cnt = bitc - 16'h1;
        next_st.rx_left = nbits - 4'h1;
        next_st.rx_sh = '0;
      end else begin
        next_st.rx_cnt = st.rx_cnt - 16'h1;
      end
      RX_DATA: if (st.rx_cnt == 16'h0) begin
        next_st.rx_sh = {rxd, st.rx_sh[11:1]};
        next_st.rx_cnt = bitc - 16'h1;
        next_st.rx_left = st.rx_left - 4'h1;
        if (st.rx_left == 4'h1) begin
          next_st.rx_st = RX_IDLE;
          next_st.rx_valid = 1'b1;
          next_st.rx_char.data = cfg.data8 ? al[7:0] : {1'b0, al[6:0]};
          next_st.rx_char.perr = par_on &&
            (al[ndata] != ((cfg.parity == serial_port_pkg::PAR_ODD) ?
            ~^next_st.rx_char.data : ^next_st.rx_char.data));
          next_st.rx_char.ferr = !al[pbit] || (cfg.stop2 && !al[pbit + 4'h1]);
        end
      end else begin
        next_st.rx_cnt = st.rx_cnt - 16'h1;
      end
      default: next_st.rx_st = RX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.tx_sh <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign txd = st.tx_sh[0];
  assign de = st.de;
  assign tx_busy = st.tx_st == TX_RUN;
  assign rx_busy = st.rx_st != RX_IDLE;
  assign rx_valid = st.rx_valid;
  assign rx_char = st.rx_char;
endmodule : serial_engine
`default_nettype wire

// >>> verilog/serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port #(
  parameter logic [serial_port_pkg::MS_DIV_W-1:0] CYC_PER_MS =
    serial_port_pkg::MS_DIV_W'(serial_port_pkg::CYC_PER_MS)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [serial_port_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // RS-485 transceiver
  input wire logic rxd,
  output logic txd,
  output logic de
);
  typedef struct packed {
    logic [1:0] rxd_sync;
    serial_port_pkg::ctrl_t ctrl;
    logic [6:0] delay_ms;
    logic [15:0] slope;
    logic [15:0] offset;
    logic [15:0] sp_in;
    logic [15:0] sp_out;
    logic [15:0] rx_chk;
    logic [15:0] tx_chk;
    logic [7:0] wr_ptr;
    logic [7:0] rd_ptr;
    logic [7:0] count;
    logic perr;
    logic ferr;
    logic overflow;
    logic msg_open;
    logic msg_mine;
    logic [6:0] wait_ms;
    logic [serial_port_pkg::MS_DIV_W-1:0] ms_div;
    logic tx_go;
    logic [7:0] tx_byte;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } core_t;

  core_t st;
  core_t next_st;
  logic [7:0] rx_mem [serial_port_pkg::RX_DEPTH];
  logic mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;
  logic tx_start;
  logic eng_tx_busy;
  logic eng_rx_busy;
  logic eng_rx_valid;
  serial_port_pkg::rx_char_t eng_rx_char;

  function automatic logic [15:0] chk_step(
    input logic [15:0] c,
    input logic [7:0] b,
    input logic modbus
  );
    logic [15:0] r;
    r = c ^ {8'h00, b};
    if (modbus) begin
      for (int i = 0; i < 8; i++) begin
        r = r[0] ? ((r >> 1) ^ serial_port_pkg::CRC_POLY) : (r >> 1);
      end
    end
    return r;
  endfunction : chk_step

  function automatic logic [7:0] wrap_inc(input logic [7:0] p);
    return (p == serial_port_pkg::RX_DEPTH - 8'h1) ? 8'h00 : p + 8'h1;
  endfunction : wrap_inc

  function automatic logic [15:0] chk_init(input logic modbus);
    return modbus ? serial_port_pkg::CRC_INIT : serial_port_pkg::BCC_INIT;
  endfunction : chk_init

  serial_engine u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(st.ctrl.line),
    .tx_start(tx_start),
    .tx_data(st.tx_byte),
    .rxd(st.rxd_sync[1]),
    .txd(txd),
    .de(de),
    .tx_busy(eng_tx_busy),
    .rx_busy(eng_rx_busy),
    .rx_valid(eng_rx_valid),
    .rx_char(eng_rx_char)
  );

  always_comb begin
    logic acc;
    logic done;
    logic hit;
    logic tx_ready;
    logic initiator;
    logic mine;
    logic [31:0] rd;
    logic [31:0] prod;
    logic [7:0] own_addr;
    serial_port_pkg::status_t status;
    serial_port_pkg::cmd_t cmd;
    acc = psel && penable;
    done = acc && st.pready;
    hit = 1'b0;
    rd = '0;
    prod = '0;
    mine = 1'b0;
    cmd = serial_port_pkg::cmd_t'(pwdata[$bits(serial_port_pkg::cmd_t)-1:0]);
    own_addr = {3'h0, st.ctrl.station};
    // Master and PLC roles open exchanges themselves
    initiator = st.ctrl.role inside {serial_port_pkg::ROLE_MASTER,
      serial_port_pkg::ROLE_PLC};
    tx_ready = !st.tx_go && !eng_tx_busy;
    next_st = st;
    mem_we = 1'b0;
    mem_wa = st.wr_ptr;
    mem_wd = eng_rx_char.data;
    next_st.rxd_sync = {st.rxd_sync[0], rxd};

    status = '0;
    status.count = st.count;
    status.delay_wait = st.tx_go && st.wait_ms != 7'h00 && !initiator;
    status.addr_match = st.msg_open && st.msg_mine;
    status.overflow = st.overflow;
    status.ferr = st.ferr;
    status.perr = st.perr;
    status.rx_avail = st.count != 8'h00;
    status.tx_ready = tx_ready;
    status.rx_busy = eng_rx_busy;
    status.tx_busy = eng_tx_busy || st.tx_go;

    case (paddr)
      serial_port_pkg::A_CTRL: begin
        hit = 1'b1;
        rd = 32'(st.ctrl);
      end
      serial_port_pkg::A_STATUS: begin
        hit = 1'b1;
        rd = 32'(status);
      end
      serial_port_pkg::A_TXDATA: begin
        hit = 1'b1;
        rd = {24'h0, st.tx_byte};
      end
      serial_port_pkg::A_RXDATA: begin
        hit = 1'b1;
        rd = {24'h0, rx_mem[st.rd_ptr]};
      end
      serial_port_pkg::A_DELAY: begin
        hit = 1'b1;
        rd = {25'h0, st.delay_ms};
      end
      serial_port_pkg::A_CHECK: begin
        hit = 1'b1;
        rd = {st.tx_chk, st.rx_chk};
      end
      serial_port_pkg::A_SCALE: begin
        hit = 1'b1;
        rd = {st.offset, st.slope};
      end
      serial_port_pkg::A_SETPT: begin
        hit = 1'b1;
        rd = {st.sp_out, st.sp_in};
      end
      serial_port_pkg::A_CMD: hit = 1'b1;
      default: hit = 1'b0;
    endcase

    // One wait state: answer is prepared in the first access cycle
    if (acc && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.prdata = pwrite ? '0 : rd;
      // No flow control: a byte offered while busy is refused, not queued
      next_st.pslverr = !hit || (pwrite && paddr == serial_port_pkg::A_TXDATA && !tx_ready);
    end else begin
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
    end

    if (done && !st.pslverr && pwrite) begin
      case (paddr)
        serial_port_pkg::A_CTRL: begin
          // Changing the format mid-character corrupts that character
          next_st.ctrl = serial_port_pkg::ctrl_t'(pwdata[$bits(serial_port_pkg::ctrl_t)-1:0]);
        end
        serial_port_pkg::A_TXDATA: begin
          next_st.tx_byte = pwdata[7:0];
          next_st.tx_go = 1'b1;
          next_st.tx_chk = chk_step(st.tx_chk, pwdata[7:0], st.ctrl.modbus);
        end
        serial_port_pkg::A_DELAY: begin
          if (pwdata[31:7] != '0 || pwdata[6:0] > serial_port_pkg::DELAY_MAX_MS) begin
            next_st.delay_ms = serial_port_pkg::DELAY_MAX_MS;
          end else begin
            next_st.delay_ms = pwdata[6:0];
          end
        end
        serial_port_pkg::A_SCALE: begin
          next_st.slope = pwdata[15:0];
          next_st.offset = pwdata[31:16];
        end
        serial_port_pkg::A_SETPT: next_st.sp_in = pwdata[15:0];
        serial_port_pkg::A_CMD: begin
          if (cmd.clr_err) begin
            next_st.perr = 1'b0;
            next_st.ferr = 1'b0;
            next_st.overflow = 1'b0;
          end
          if (cmd.clr_tx_chk) begin
            next_st.tx_chk = chk_init(st.ctrl.modbus);
          end
          if (cmd.new_msg) begin
            next_st.wr_ptr = 8'h00;
            next_st.rd_ptr = 8'h00;
            next_st.count = 8'h00;
            next_st.msg_open = 1'b0;
            next_st.msg_mine = 1'b0;
            next_st.rx_chk = chk_init(st.ctrl.modbus);
          end
        end
        default: next_st.tx_go = st.tx_go;
      endcase
    end

    if (done && !pwrite && paddr == serial_port_pkg::A_RXDATA && st.count != 8'h00) begin
      next_st.rd_ptr = wrap_inc(st.rd_ptr);
      next_st.count = next_st.count - 8'h1;
    end

    // Receive path runs after the commands so a new byte wins over a clear
    if (eng_rx_valid) begin
      if (!next_st.msg_open) begin
        mine = initiator || eng_rx_char.data == own_addr ||
          eng_rx_char.data == serial_port_pkg::BCAST_ADDR;
        next_st.msg_open = 1'b1;
        next_st.msg_mine = mine;
      end else begin
        mine = next_st.msg_mine;
      end
      if (mine) begin
        // Built on next_st so a clear in this cycle is kept unless a new error sets it
        next_st.perr = next_st.perr || eng_rx_char.perr;
        next_st.ferr = next_st.ferr || eng_rx_char.ferr;
        next_st.rx_chk = chk_step(next_st.rx_chk, eng_rx_char.data, st.ctrl.modbus);
        if (next_st.count == serial_port_pkg::RX_DEPTH) begin
          next_st.overflow = 1'b1;
        end else begin
          mem_we = 1'b1;
          mem_wa = next_st.wr_ptr;
          next_st.wr_ptr = wrap_inc(next_st.wr_ptr);
          next_st.count = next_st.count + 8'h1;
        end
      end
      // Every heard character restarts the reply delay
      next_st.wait_ms = st.delay_ms;
      next_st.ms_div = '0;
    end else if (st.wait_ms != 7'h00) begin
      if (st.ms_div == CYC_PER_MS - 1'b1) begin
        next_st.ms_div = '0;
        next_st.wait_ms = st.wait_ms - 7'h01;
      end else begin
        next_st.ms_div = st.ms_div + 1'b1;
      end
    end

    // Copy and set-point traffic is carried byte by byte from TXDATA
    tx_start = st.tx_go && !eng_tx_busy && !eng_rx_busy &&
      (initiator || st.wait_ms == 7'h00);
    if (tx_start) begin
      next_st.tx_go = 1'b0;
    end

    prod = 32'($signed(st.sp_in) * $signed(st.slope));
    if (st.ctrl.role == serial_port_pkg::ROLE_SLAVE) begin
      next_st.sp_out = prod[serial_port_pkg::SCALE_SHIFT +: 16] + st.offset;
    end else begin
      next_st.sp_out = st.sp_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.rxd_sync <= '1;
      st.ctrl <= serial_port_pkg::CTRL_RESET;
      st.delay_ms <= serial_port_pkg::DELAY_DEF_MS;
      st.slope <= serial_port_pkg::SLOPE_UNITY;
      st.rx_chk <= serial_port_pkg::BCC_INIT;
      st.tx_chk <= serial_port_pkg::BCC_INIT;
    end else begin
      st <= next_st;
    end
  end

  // Buffer holds no reset; count and pointers say what is valid
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      rx_mem[mem_wa] <= mem_wd;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
endmodule : serial_port
`default_nettype wire

// >>> sim/serial_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [serial_port_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line
  input wire logic rxd,
  input wire logic txd,
  input wire logic de
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait_state: assert property (
    psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_err_unmapped: assert property (
    psel && penable && pready && paddr > 8'h20 |-> pslverr)
    else $error("unmapped address without pslverr");
  a_read_mapped_ok: assert property (
    pready && !pwrite && paddr <= 8'h20 |-> !pslverr)
    else $error("pslverr on mapped read");
  a_write_rdata_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("prdata not zero on write");
  a_line_idle_high: assert property (!de |-> txd)
    else $error("txd low while not driving");
  a_start_bit_held: assert property ($rose(de) |-> (de && !txd) [*8])
    else $error("start bit not held");
endmodule : serial_port_asserts
bind serial_port serial_port_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .de(de));
`default_nettype wire

// >>> sim/line_station.sv
`timescale 1ns/1ps
`default_nettype none
module line_station #(
  parameter int BITC = 3472
) (
  // Clock and format
  input wire logic pclk,
  input wire serial_port_pkg::line_cfg_t cfg,
  // Send request
  input wire logic send,
  input wire logic [7:0] send_byte,
  // Line
  input wire logic txd,
  input wire logic de,
  output logic rxd,
  // Received character
  output logic got,
  output logic [7:0] got_byte,
  output logic got_ok
);
  function automatic logic par_bit(input logic [7:0] b, input serial_port_pkg::line_cfg_t c);
    par_bit = (c.data8 ? ^b : ^b[6:0]) ^ (c.parity == serial_port_pkg::PAR_ODD);
  endfunction : par_bit
  task automatic put_bit(input logic v);
    rxd <= v;
    repeat (BITC) @(posedge pclk);
  endtask : put_bit
  // Biased line rests high once the stop bit ends
  initial begin : tx_loop
    int i;
    rxd = 1'b1;
    forever begin
      @(posedge pclk);
      if (send) begin
        wait (de !== 1'b1);
        put_bit(1'b0);
        for (i = 0; i < (cfg.data8 ? 8 : 7); i++) put_bit(send_byte[i]);
        if (cfg.parity != serial_port_pkg::PAR_NONE) put_bit(par_bit(send_byte, cfg));
        put_bit(1'b1);
        if (cfg.stop2) put_bit(1'b1);
      end
    end
  end
  initial begin : rx_loop
    logic [7:0] b;
    logic ok;
    int i;
    got = 1'b0;
    got_byte = 8'h00;
    got_ok = 1'b0;
    forever begin
      @(posedge de);
      ok = 1'b1;
      b = 8'h00;
      repeat (BITC / 2) @(posedge pclk);
      ok &= (txd === 1'b0) && (de === 1'b1);
      for (i = 0; i < (cfg.data8 ? 8 : 7); i++) begin
        repeat (BITC) @(posedge pclk);
        b[i] = txd;
      end
      if (cfg.parity != serial_port_pkg::PAR_NONE) begin
        repeat (BITC) @(posedge pclk);
        ok &= (txd === par_bit(b, cfg));
      end
      for (i = 0; i < (cfg.stop2 ? 2 : 1); i++) begin
        repeat (BITC) @(posedge pclk);
        ok &= (txd === 1'b1) && (de === 1'b1);
      end
      repeat (BITC / 2 + 4) @(posedge pclk);
      ok &= (de === 1'b0);
      got_byte <= b;
      got_ok <= ok;
      got <= 1'b1;
      @(posedge pclk);
      got <= 1'b0;
    end
  end
endmodule : line_station
`default_nettype wire

// >>> sim/serial_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_tb;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] mask;
    logic err;
    logic [7:0] addr;
  } note_t;
  localparam logic [7:0] RA [6] = '{8'h00, 8'h10, 8'h18, 8'h04, 8'h14, 8'h20};
  localparam logic [31:0] RE [6] = '{32'h48, 32'h14, 32'h100, 32'h4, 32'h0, 32'h0};
  localparam logic [31:0] RM [6] = '{'1, '1, '1, 32'h7F, '1, '1};
  logic pclk, presetn, psel, penable, pwrite, rxd, txd, de, pready, pslverr;
  logic send, got, got_ok, chk;
  logic [7:0] paddr, got_byte;
  logic [31:0] pwdata, prdata, rq;
  logic [15:0] sp;
  logic [8:0] ln;
  serial_port_pkg::line_cfg_t pcfg;
  note_t bn;
  note_t bus_q[$];
  logic [8:0] line_q[$];
  int n_errors, comparisons, cyc, seed, t0, i;

  serial_port #(.CYC_PER_MS(18'd20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .de(de));
  line_station #(.BITC(3472)) peer (.pclk(pclk), .cfg(pcfg), .send(send),
    .send_byte(8'h01), .txd(txd), .de(de), .rxd(rxd), .got(got), .got_byte(got_byte),
    .got_ok(got_ok));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic finish_test();
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic c, input logic [31:0] ex, input logic [31:0] m, input logic er);
    @(posedge pclk);
    chk = c;
    if (c) bus_q.push_back('{ex & m, m, er, a});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge; data taken there
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  // Oldest note is matched against each checked transfer and each character heard
  always @(negedge pclk) begin
    if (pready === 1'b1 && chk) begin
      bn = bus_q.pop_front();
      comparisons++;
      if ((prdata & bn.mask) !== bn.exp || pslverr !== bn.err) begin
        n_errors++;
        $display("Error reg %h expected %h/%b seen %h/%b", bn.addr, bn.exp, bn.err,
                 prdata & bn.mask, pslverr);
      end
    end
    if (got === 1'b1) begin
      ln = line_q.pop_front();
      comparisons++;
      if ({got_ok, got_byte} !== ln) begin
        n_errors++;
        $display("Error line char expected %h seen %h", ln, {got_ok, got_byte});
      end
    end
  end

  // Bound covers two full line frames and the register traffic
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 95000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    send = 1'b0;
    chk = 1'b0;
    presetn = 1'b0;
    seed = 92;
    pcfg = '{2'h3, 1'b1, 1'b0, serial_port_pkg::PAR_EVEN};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i++) bus(1'b0, RA[i], 32'h0, 1'b1, RE[i], RM[i], 1'b0);
    bus(1'b0, 8'h24, 32'h0, 1'b1, 32'h0, 32'h0, 1'b1);
    bus(1'b1, 8'h30, 32'h5A, 1'b1, 32'h0, '1, 1'b1);
    bus(1'b1, 8'h10, 32'h7F, 1'b0, 32'h0, 32'h0, 1'b0);
    bus(1'b0, 8'h10, 32'h0, 1'b1, 32'h63, '1, 1'b0);
    bus(1'b1, 8'h10, 32'h5, 1'b0, 32'h0, 32'h0, 1'b0);
    bus(1'b0, 8'h10, 32'h0, 1'b1, 32'h5, '1, 1'b0);
    bus(1'b1, 8'h00, 32'h1048, 1'b0, 32'h0, 32'h0, 1'b0);
    bus(1'b1, 8'h18, 32'h00100200, 1'b0, 32'h0, 32'h0, 1'b0);
    for (i = 0; i < 4; i++) begin
      sp = 16'($random(seed)) & 16'h0FFF;
      bus(1'b1, 8'h1C, {16'h0, sp}, 1'b0, 32'h0, 32'h0, 1'b0);
      bus(1'b0, 8'h1C, 32'h0, 1'b1, {sp * 16'h2 + 16'h10, sp}, '1, 1'b0);
    end
    bus(1'b1, 8'h00, 32'h48, 1'b0, 32'h0, 32'h0, 1'b0);
    bus(1'b1, 8'h1C, {16'h0, sp}, 1'b0, 32'h0, 32'h0, 1'b0);
    bus(1'b0, 8'h1C, 32'h0, 1'b1, {sp, sp}, '1, 1'b0);
    // 57600 bit/s, 8 data, even parity, 1 stop, station 1
    bus(1'b1, 8'h00, 32'h79, 1'b0, 32'h0, 32'h0, 1'b0);
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    i = 0;
    do begin
      bus(1'b0, 8'h04, 32'h0, 1'b0, 32'h0, 32'h0, 1'b0);
      i++;
    end while (rq[3] !== 1'b1 && i < 15000);
    t0 = cyc;
    bus(1'b0, 8'h04, 32'h0, 1'b1, 32'h88, 32'hF8, 1'b0);
    // Reply as 7 data, odd parity, 2 stop at the same rate
    pcfg <= '{2'h3, 1'b0, 1'b1, serial_port_pkg::PAR_ODD};
    bus(1'b1, 8'h00, 32'h76, 1'b0, 32'h0, 32'h0, 1'b0);
    line_q.push_back({1'b1, 8'h35});
    bus(1'b1, 8'h08, 32'h35, 1'b1, 32'h0, 32'h0, 1'b0);
    i = 0;
    while (de !== 1'b1 && i < 300) begin
      @(negedge pclk);
      i++;
    end
    comparisons++;
    if (cyc - t0 < 90 || cyc - t0 > 110) begin
      n_errors++;
      $display("Error reply delay expected 90..110 seen %0d", cyc - t0);
    end
    bus(1'b0, 8'h0C, 32'h0, 1'b1, 32'h01, 32'hFF, 1'b0);
    bus(1'b0, 8'h14, 32'h0, 1'b1, 32'h0001, 32'hFFFF, 1'b0);
    i = 0;
    while (line_q.size() != 0 && i < 45000) begin
      @(posedge pclk);
      i++;
    end
    bus(1'b0, 8'h14, 32'h0, 1'b1, 32'h00350000, 32'hFFFF0000, 1'b0);
    bus(1'b0, 8'h04, 32'h0, 1'b1, 32'h04, 32'h0F, 1'b0);
    // Modbus: both checks restart from the CRC seed, then one byte is folded in
    bus(1'b1, 8'h00, 32'h2048, 1'b0, 32'h0, 32'h0, 1'b0);
    bus(1'b1, 8'h20, 32'h7, 1'b1, 32'h0, '1, 1'b0);
    bus(1'b0, 8'h14, 32'h0, 1'b1, 32'hFFFFFFFF, '1, 1'b0);
    bus(1'b1, 8'h08, 32'h01, 1'b0, 32'h0, 32'h0, 1'b0);
    bus(1'b0, 8'h14, 32'h0, 1'b1, 32'h807EFFFF, '1, 1'b0);
    // A character or answer that never came leaves its note behind
    comparisons++;
    if (line_q.size() != 0 || bus_q.size() != 0) begin
      n_errors++;
      $display("Error pending notes expected 0 seen %0d", line_q.size() + bus_q.size());
    end
    finish_test();
  end
endmodule : serial_port_tb
`default_nettype wire
